// >>> sfd_params.svh
`ifndef SFD_PARAMS_SVH
`define SFD_PARAMS_SVH

// ----------------------------------------
// Channel counts
// ----------------------------------------
`define SFD_NCH          10
`define SFD_NDUAL        5
`define SFD_NSYNC        25

// ----------------------------------------
// Timing
// ----------------------------------------
`define SFD_CLK_NS       10
`define SFD_FILT_MAX_US  100
`define SFD_FILT_MAX_CYC ((`SFD_FILT_MAX_US * 1000) / `SFD_CLK_NS)

// ----------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------
`define SFD_CFG_BASE     8'h00
`define SFD_CFG_STRIDE   8
`define SFD_FILT_OFS     8'h04
`define SFD_UV_STAT      8'h50
`define SFD_OV_STAT      8'h54
`define SFD_WARN_STAT    8'h58

// ----------------------------------------
// Field positions
// ----------------------------------------
`define SFD_UVTH_LSB     0
`define SFD_OVTH_LSB     8
`define SFD_HYST_LSB     16
`define SFD_MODE_LSB     22
`define SFD_RANGE_LSB    24
`define SFD_LOGIC_BIT    26
`define SFD_LVL_LSB      8

// ----------------------------------------
// Encodings and reset values
// ----------------------------------------
`define SFD_MODE_UV      2'h0
`define SFD_MODE_OV      2'h1
`define SFD_MODE_WIN     2'h2
`define SFD_RANGE_LOW    2'h0
`define SFD_RESP_OKAY    2'h0
`define SFD_RESP_SLVERR  2'h2
`define SFD_CFG_RST      32'h0000_0000
`define SFD_FILT_RST     14'h0000

`endif

// >>> sfd_pkg.sv
package sfd_pkg;

  // ----------------------------------------
  // Scalar types
  // ----------------------------------------
  typedef logic [7:0]  sfd_code_t;   // Threshold code
  typedef logic [4:0]  sfd_hyst_t;   // Hysteresis code
  typedef logic [13:0] sfd_cnt_t;    // Filter cycle count

  // Per-channel configuration
  typedef struct packed {
    sfd_code_t   uv_th;
    sfd_code_t   ov_th;
    sfd_hyst_t   hyst;
    logic [1:0]  mode;
    logic [1:0]  range;
    logic        logic_sel;
  } sfd_cfg_t;

  // Input synchroniser state
  typedef struct packed {
    logic [24:0] s1;
    logic [24:0] s2;
    logic [24:0] s3;
    logic [24:0] stable;
  } sfd_sync_t;

  // Glitch filter state
  typedef struct packed {
    logic     q;
    sfd_cnt_t cnt;
  } sfd_filt_t;

  // Top-level state
  typedef struct packed {
    sfd_cfg_t  [9:0] cfg;
    sfd_cnt_t  [9:0] filt;
    logic            aw_got;
    logic            w_got;
    logic [7:0]      awaddr;
    logic [31:0]     wdata;
    logic [3:0]      wstrb;
    logic            bvalid;
    logic [1:0]      bresp;
    logic            rvalid;
    logic [31:0]     rdata;
    logic [1:0]      rresp;
    logic [9:0]      uv_fault;
    logic [9:0]      ov_fault;
    logic [4:0]      warning;
    logic            warning_any;
    logic [4:0]      logic_level;
    sfd_code_t [9:0] uv_level;
    sfd_code_t [9:0] ov_level;
    logic [9:0][1:0] range_sel;
    logic [4:0]      warning_route;
  } sfd_top_t;

endpackage

// >>> sfd_sync.sv
`timescale 1ns/100ps
`include "sfd_params.svh"

module sfd_sync (
  input  wire logic                  aclk,
  input  wire logic                  aresetn,
  input  wire logic [`SFD_NSYNC-1:0] d,
  output logic      [`SFD_NSYNC-1:0] q
);
  import sfd_pkg::*;

  sfd_sync_t st;       // Registered state
  sfd_sync_t next_st;  // Next state

  // ----------------------------------------
  // Three stages; change taken when 2 and 3 agree
  // ----------------------------------------
  always_comb begin
    next_st        = st;
    next_st.s1     = d;
    next_st.s2     = st.s1;
    next_st.s3     = st.s2;
    next_st.stable = (st.s2 & st.s3) | (st.stable & (st.s2 | st.s3));
    if (!aresetn) begin
      next_st = '0;
    end
  end

  // State register
  always_ff @(posedge aclk) begin
    st <= next_st;
  end

  assign q = st.stable;

endmodule

// >>> sfd_glitch_filter.sv
`timescale 1ns/100ps

module sfd_glitch_filter (
  input  wire logic                aclk,
  input  wire logic                aresetn,
  input  wire logic                d,
  input  wire sfd_pkg::sfd_cnt_t   limit,
  output logic                     q
);
  import sfd_pkg::*;

  sfd_filt_t st;       // Registered state
  sfd_filt_t next_st;  // Next state
  logic      expire;   // Mismatch has lasted the full count

  assign expire = ({1'b0, st.cnt} + 15'h0001) >= {1'b0, limit};

  // ----------------------------------------
  // Follow input only after a stable run
  // ----------------------------------------
  always_comb begin
    next_st = st;
    if (d == st.q) begin
      next_st.cnt = '0;
    end else if (expire) begin
      next_st.q   = d;
      next_st.cnt = '0;
    end else begin
      next_st.cnt = 14'(st.cnt + 14'h0001);
    end
    if (!aresetn) begin
      next_st = '0;
    end
  end

  // State register
  always_ff @(posedge aclk) begin
    st <= next_st;
  end

  assign q = st.q;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  property p_short_blocked;
    @(posedge aclk) disable iff (!aresetn)
    !$stable(st.q) |-> $past(expire) && $past(d != st.q);
  endproperty
  a_short_blocked: assert property (p_short_blocked)
    else $error("filter output moved before timeout");

  property p_long_passed;
    @(posedge aclk) disable iff (!aresetn)
    (d != st.q) && expire |=> st.q == $past(d);
  endproperty
  a_long_passed: assert property (p_long_passed)
    else $error("filter output missed expired input");

endmodule

// >>> sfd_top.sv
// The AXI4-Lite slave port and the register offsets are this design's own decisions.
`timescale 1ns/100ps
`include "sfd_params.svh"

// Behaviour
// - Ten channels: five dedicated, five dual-purpose
// - Dual channel: analog detector or logic, never both
// - Modes: undervoltage, overvoltage, or window
// - Thresholds are 8-bit codes, 255 steps
// - Threshold equals range bottom plus span times code/255
// - Four ranges, selectable on channels 0-4; dual channels use range 0, or the paired channel's range in logic mode
// - Comparators evaluate continuously, regardless of fault
// - Undervoltage release point raised by hysteresis
// - Overvoltage release point lowered by hysteresis
// - Hysteresis is 5-bit code, span times code/255
// - Hysteresis code limited to 31
// - Glitch filter last stage, up to 100 us
// - Pulses shorter than timeout are blocked
// - Longer pulses pass, delayed by timeout
// - Filter independent of comparator hysteresis
// - Logic-mode dual detector warns on paired input
// - Warnings readable and ORed into one signal
module sfd_top #(
  parameter logic [13:0] FILT_MAX_CYCLES = 14'(`SFD_FILT_MAX_CYC)
) (
  input  wire logic                    aclk,
  input  wire logic                    aresetn,
  // AXI4-Lite slave
  input  wire logic [7:0]              s_axi_awaddr,
  input  wire logic                    s_axi_awvalid,
  output logic                         s_axi_awready,
  input  wire logic [31:0]             s_axi_wdata,
  input  wire logic [3:0]              s_axi_wstrb,
  input  wire logic                    s_axi_wvalid,
  output logic                         s_axi_wready,
  output logic [1:0]                   s_axi_bresp,
  output logic                         s_axi_bvalid,
  input  wire logic                    s_axi_bready,
  input  wire logic [7:0]              s_axi_araddr,
  input  wire logic                    s_axi_arvalid,
  output logic                         s_axi_arready,
  output logic [31:0]                  s_axi_rdata,
  output logic [1:0]                   s_axi_rresp,
  output logic                         s_axi_rvalid,
  input  wire logic                    s_axi_rready,
  // Comparator results and logic pins
  input  wire logic [9:0]              uv_cmp_in,
  input  wire logic [9:0]              ov_cmp_in,
  input  wire logic [4:0]              dual_logic_in,
  // Codes and ranges to the comparators
  output sfd_pkg::sfd_code_t [9:0]     uv_level_code,
  output sfd_pkg::sfd_code_t [9:0]     ov_level_code,
  output logic [9:0][1:0]              range_sel,
  output logic [4:0]                   warning_route,
  // Results to the sequencing engine
  output logic [9:0]                   undervoltage_fault,
  output logic [9:0]                   overvoltage_fault,
  output logic [4:0]                   warning,
  output logic                         warning_any,
  output logic [4:0]                   logic_level
);
  import sfd_pkg::*;

  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  sfd_top_t    st;        // Registered state
  sfd_top_t    next_st;   // Next state
  logic [24:0] sync_q;    // Synchronised comparator/pin levels
  logic [24:0] filt_q;    // Filtered levels
  logic [9:0]  det_uv;    // Undervoltage detector asserted
  logic [9:0]  det_ov;    // Overvoltage detector asserted
  logic [9:0]  ov_only;   // Channel in overvoltage-only mode
  logic [4:0]  sel_v;     // Dual channels in logic mode

  // ----------------------------------------
  // Helper functions
  // ----------------------------------------
  // Register word from configuration
  function automatic logic [31:0] cfg_pack(input sfd_cfg_t c);
    logic [31:0] w;
    w = '0;
    w[`SFD_UVTH_LSB +: 8]  = c.uv_th;
    w[`SFD_OVTH_LSB +: 8]  = c.ov_th;
    w[`SFD_HYST_LSB +: 5]  = c.hyst;
    w[`SFD_MODE_LSB +: 2]  = c.mode;
    w[`SFD_RANGE_LSB +: 2] = c.range;
    w[`SFD_LOGIC_BIT]      = c.logic_sel;
    return w;
  endfunction

  // Configuration from word; logic mode only on dual channels
  function automatic sfd_cfg_t cfg_unpack(input logic [31:0] w,
                                          input logic        dual);
    sfd_cfg_t c;
    c.uv_th     = w[`SFD_UVTH_LSB +: 8];
    c.ov_th     = w[`SFD_OVTH_LSB +: 8];
    c.hyst      = w[`SFD_HYST_LSB +: 5];
    c.mode      = w[`SFD_MODE_LSB +: 2];
    c.range     = w[`SFD_RANGE_LSB +: 2];
    c.logic_sel = dual & w[`SFD_LOGIC_BIT];
    return c;
  endfunction

  // Byte-lane merge for write strobes
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0]  strb);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        r[8*b +: 8] = nw[8*b +: 8];
      end
    end
    return r;
  endfunction

  // Raised undervoltage release code, saturating
  function automatic sfd_code_t hyst_up(input sfd_code_t th,
                                        input sfd_hyst_t h);
    logic [8:0] s;
    s = {1'b0, th} + {4'h0, h};
    return s[8] ? 8'hFF : s[7:0];
  endfunction

  // Lowered overvoltage release code, floored at zero
  function automatic sfd_code_t hyst_dn(input sfd_code_t th,
                                        input sfd_hyst_t h);
    return (th > {3'h0, h}) ? 8'(th - {3'h0, h}) : 8'h00;
  endfunction

  // Configuration word address of a channel
  function automatic logic [7:0] cfg_addr(input int i);
    return 8'(`SFD_CFG_BASE + i * `SFD_CFG_STRIDE);
  endfunction

  // Timeout word after a strobed write, clamped to the limit
  function automatic sfd_cnt_t filt_next(input sfd_cnt_t    old,
                                         input logic [31:0] nw,
                                         input logic [3:0]  strb,
                                         input sfd_cnt_t    lim);
    logic [31:0] w;  // Merged word
    w = merge({18'h0, old}, nw, strb);
    return (w > {18'h0, lim}) ? lim : w[13:0];
  endfunction

  // ----------------------------------------
  // Input synchronisers
  // ----------------------------------------
  sfd_sync u_sync (
    .aclk    (aclk),
    .aresetn (aresetn),
    .d       ({dual_logic_in, ov_cmp_in, uv_cmp_in}),
    .q       (sync_q)
  );

  // ----------------------------------------
  // Glitch filters: uv 0-9, ov 10-19, logic 20-24
  // ----------------------------------------
  genvar g;
  generate
    for (g = 0; g < `SFD_NSYNC; g++) begin : gen_filt
      localparam int CH = (g < 10) ? g : (g < 20) ? g - 10 : g - 15;
      sfd_glitch_filter u_filt (
        .aclk    (aclk),
        .aresetn (aresetn),
        .d       (sync_q[g]),
        .limit   (st.filt[CH]),
        .q       (filt_q[g])
      );
    end
    // Mode decode per channel
    for (g = 0; g < `SFD_NCH; g++) begin : gen_det
      assign det_uv[g]  = filt_q[g] &
                          ((st.cfg[g].mode == `SFD_MODE_UV) ||
                           (st.cfg[g].mode == `SFD_MODE_WIN));
      assign det_ov[g]  = filt_q[g+10] &
                          ((st.cfg[g].mode == `SFD_MODE_OV) ||
                           (st.cfg[g].mode == `SFD_MODE_WIN));
      assign ov_only[g] = st.cfg[g].mode == `SFD_MODE_OV;
    end
    for (g = 0; g < `SFD_NDUAL; g++) begin : gen_sel
      assign sel_v[g] = st.cfg[g+5].logic_sel;
    end
  endgenerate

  // ----------------------------------------
  // Next-state logic
  // ----------------------------------------
  always_comb begin
    next_st = st;
    // Write address and data, either order
    if (s_axi_awvalid && s_axi_awready) begin
      next_st.aw_got = 1'b1;
      next_st.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_st.w_got = 1'b1;
      next_st.wdata = s_axi_wdata;
      next_st.wstrb = s_axi_wstrb;
    end
    // Response taken
    if (st.bvalid && s_axi_bready) begin
      next_st.bvalid = 1'b0;
    end
    // Perform write once both halves held
    if (st.aw_got && st.w_got) begin
      next_st.aw_got = 1'b0;
      next_st.w_got  = 1'b0;
      next_st.bvalid = 1'b1;
      next_st.bresp  = `SFD_RESP_SLVERR;
      for (int i = 0; i < `SFD_NCH; i++) begin
        if (st.awaddr == cfg_addr(i)) begin
          next_st.cfg[i] = cfg_unpack(merge(cfg_pack(st.cfg[i]),
                                            st.wdata, st.wstrb),
                                      i >= 5);
          next_st.bresp  = `SFD_RESP_OKAY;
        end
        if (st.awaddr == cfg_addr(i) + `SFD_FILT_OFS) begin
          // Timeout clamped to the longest allowed
          next_st.filt[i] = filt_next(st.filt[i], st.wdata, st.wstrb,
                                      FILT_MAX_CYCLES);
          next_st.bresp   = `SFD_RESP_OKAY;
        end
      end
      // Status words are read-only; writes ignored
      if (st.awaddr == `SFD_UV_STAT || st.awaddr == `SFD_OV_STAT ||
          st.awaddr == `SFD_WARN_STAT) begin
        next_st.bresp = `SFD_RESP_OKAY;
      end
    end
    // Read data taken
    if (st.rvalid && s_axi_rready) begin
      next_st.rvalid = 1'b0;
    end
    // Read address accepted
    if (s_axi_arvalid && s_axi_arready) begin
      next_st.rvalid = 1'b1;
      next_st.rdata  = '0;
      next_st.rresp  = `SFD_RESP_SLVERR;
      for (int i = 0; i < `SFD_NCH; i++) begin
        if (s_axi_araddr == cfg_addr(i)) begin
          next_st.rdata = cfg_pack(st.cfg[i]);
          next_st.rresp = `SFD_RESP_OKAY;
        end
        if (s_axi_araddr == cfg_addr(i) + `SFD_FILT_OFS) begin
          next_st.rdata = {18'h0, st.filt[i]};
          next_st.rresp = `SFD_RESP_OKAY;
        end
      end
      case (s_axi_araddr)
        `SFD_UV_STAT: begin
          next_st.rdata = {22'h0, st.uv_fault};
          next_st.rresp = `SFD_RESP_OKAY;
        end
        `SFD_OV_STAT: begin
          next_st.rdata = {22'h0, st.ov_fault};
          next_st.rresp = `SFD_RESP_OKAY;
        end
        `SFD_WARN_STAT: begin
          next_st.rdata = '0;
          next_st.rdata[4:0] = st.warning;
          next_st.rdata[`SFD_LVL_LSB +: 5] = st.logic_level;
          next_st.rresp = `SFD_RESP_OKAY;
        end
        default: begin
        end
      endcase
    end
    // Detector results and comparator codes
    for (int i = 0; i < `SFD_NCH; i++) begin
      next_st.uv_fault[i] = det_uv[i];
      next_st.ov_fault[i] = det_ov[i];
      // Release point moves only while asserted
      next_st.uv_level[i] = det_uv[i]
                          ? hyst_up(st.cfg[i].uv_th, st.cfg[i].hyst)
                          : st.cfg[i].uv_th;
      next_st.ov_level[i] = det_ov[i]
                          ? hyst_dn(st.cfg[i].ov_th, st.cfg[i].hyst)
                          : st.cfg[i].ov_th;
      next_st.range_sel[i] = st.cfg[i].range;
    end
    // Dual channels: analog, or logic plus warning detector
    for (int k = 0; k < `SFD_NDUAL; k++) begin
      next_st.warning_route[k] = sel_v[k];
      if (sel_v[k]) begin
        next_st.uv_fault[k+5]  = 1'b0;
        next_st.ov_fault[k+5]  = 1'b0;
        next_st.warning[k]     = det_uv[k+5] | det_ov[k+5];
        next_st.logic_level[k] = filt_q[k+20];
        next_st.range_sel[k+5] = st.cfg[k].range;
      end else begin
        next_st.warning[k]     = 1'b0;
        next_st.logic_level[k] = 1'b0;
        next_st.range_sel[k+5] = `SFD_RANGE_LOW;
      end
    end
    next_st.warning_any = |next_st.warning;
    // Synchronous reset
    if (!aresetn) begin
      next_st = '0;
      for (int i = 0; i < `SFD_NCH; i++) begin
        next_st.cfg[i]  = cfg_unpack(`SFD_CFG_RST, 1'b0);
        next_st.filt[i] = `SFD_FILT_RST;
      end
    end
  end

  // State register
  always_ff @(posedge aclk) begin
    st <= next_st;
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign s_axi_awready      = !st.aw_got && !st.bvalid;
  assign s_axi_wready       = !st.w_got && !st.bvalid;
  assign s_axi_bvalid       = st.bvalid;
  assign s_axi_bresp        = st.bresp;
  assign s_axi_arready      = !st.rvalid;
  assign s_axi_rvalid       = st.rvalid;
  assign s_axi_rdata        = st.rdata;
  assign s_axi_rresp        = st.rresp;
  assign uv_level_code      = st.uv_level;
  assign ov_level_code      = st.ov_level;
  assign range_sel          = st.range_sel;
  assign warning_route      = st.warning_route;
  assign undervoltage_fault = st.uv_fault;
  assign overvoltage_fault  = st.ov_fault;
  assign warning            = st.warning;
  assign warning_any        = st.warning_any;
  assign logic_level        = st.logic_level;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  property p_excl;
    @(posedge aclk) disable iff (!aresetn)
    ((st.uv_fault[9:5] | st.ov_fault[9:5]) & $past(sel_v)) == 5'h00 &&
    (st.logic_level & ~$past(sel_v)) == 5'h00;
  endproperty
  a_excl: assert property (p_excl)
    else $error("dual channel shows both functions");

  property p_mode_ov;
    @(posedge aclk) disable iff (!aresetn)
    (st.uv_fault & $past(ov_only)) == 10'h000;
  endproperty
  a_mode_ov: assert property (p_mode_ov)
    else $error("undervoltage fault in overvoltage mode");

  property p_uv_hyst;
    @(posedge aclk) disable iff (!aresetn)
    det_uv[0] |=> st.uv_level[0] ==
      hyst_up($past(st.cfg[0].uv_th), $past(st.cfg[0].hyst));
  endproperty
  a_uv_hyst: assert property (p_uv_hyst)
    else $error("undervoltage release code wrong");

  property p_uv_plain;
    @(posedge aclk) disable iff (!aresetn)
    !det_uv[0] |=> st.uv_level[0] == $past(st.cfg[0].uv_th);
  endproperty
  a_uv_plain: assert property (p_uv_plain)
    else $error("hysteresis applied without fault");

  property p_ov_hyst;
    @(posedge aclk) disable iff (!aresetn)
    det_ov[0] |=> st.ov_level[0] ==
      hyst_dn($past(st.cfg[0].ov_th), $past(st.cfg[0].hyst));
  endproperty
  a_ov_hyst: assert property (p_ov_hyst)
    else $error("overvoltage release code wrong");

  property p_clamp;
    @(posedge aclk) disable iff (!aresetn)
    st.filt[0] <= FILT_MAX_CYCLES && st.filt[9] <= FILT_MAX_CYCLES;
  endproperty
  a_clamp: assert property (p_clamp)
    else $error("filter timeout above limit");

  property p_route;
    @(posedge aclk) disable iff (!aresetn)
    st.warning_route == $past(sel_v);
  endproperty
  a_route: assert property (p_route)
    else $error("warning route does not follow mode");

  property p_warn_or;
    @(posedge aclk) disable iff (!aresetn)
    warning_any == (|st.warning);
  endproperty
  a_warn_or: assert property (p_warn_or)
    else $error("combined warning mismatch");

  property p_bhold;
    @(posedge aclk) disable iff (!aresetn)
    st.bvalid && !s_axi_bready |=> st.bvalid && $stable(st.bresp);
  endproperty
  a_bhold: assert property (p_bhold)
    else $error("write response dropped early");

endmodule

// >>> sfd_rail_model.sv
`timescale 1ns/100ps

// ----------------------------------------
// Supervised rails seen through comparators
// ----------------------------------------
module sfd_rail_model (
  input  wire logic [9:0][8:0]        rail,
  input  wire sfd_pkg::sfd_code_t [9:0] uv_code,
  input  wire sfd_pkg::sfd_code_t [9:0] ov_code,
  input  wire logic [4:0]             route,
  output logic [9:0]                  uv_cmp,
  output logic [9:0]                  ov_cmp
);
  import sfd_pkg::*;
  logic [9:0][8:0] seen;  // Rail each comparator watches

  // Rails in code steps of the selected range; compare live
  always_comb begin
    seen = rail;
    for (int k = 0; k < 5; k++) begin
      if (route[k]) begin
        seen[5+k] = rail[k];
      end
    end
    for (int i = 0; i < 10; i++) begin
      uv_cmp[i] = seen[i] < {1'b0, uv_code[i]};
      ov_cmp[i] = seen[i] > {1'b0, ov_code[i]};
    end
  end
endmodule

// >>> test_supply_fault_detector_logic.sv
`timescale 1ns/100ps
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin \
  miscompares++; $display("[FAIL] %s exp %0h got %0h", n, e, g); end end

module test_supply_fault_detector_logic;
  import sfd_pkg::*;
  localparam logic [13:0] FMAX = 14'h0014;  // Short filter ceiling
  // ----------------------------------------
  // Signals
  // ----------------------------------------
  logic            aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic            awready, wready, bvalid, arready, rvalid, warn_any;
  logic [7:0]      awaddr, araddr;
  logic [31:0]     wdata, rdata, rd;
  logic [3:0]      wstrb;
  logic [1:0]      bresp, rresp, rsp;
  logic [9:0]      uv_cmp, ov_cmp, uvf, ovf;
  logic [4:0]      dual_in, route, warn, lvl;
  sfd_code_t [9:0] uv_code, ov_code;
  logic [9:0][1:0] rng;
  logic [9:0][8:0] rail;
  int              miscompares, total_checks, cyc;

  sfd_top #(.FILT_MAX_CYCLES(FMAX)) i_dut (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .uv_cmp_in(uv_cmp),
    .ov_cmp_in(ov_cmp), .dual_logic_in(dual_in), .uv_level_code(uv_code),
    .ov_level_code(ov_code), .range_sel(rng), .warning_route(route),
    .undervoltage_fault(uvf), .overvoltage_fault(ovf), .warning(warn),
    .warning_any(warn_any), .logic_level(lvl));

  sfd_rail_model i_rails (.rail(rail), .uv_code(uv_code), .ov_code(ov_code),
    .route(route), .uv_cmp(uv_cmp), .ov_cmp(ov_cmp));

  // Free-running 100 MHz clock
  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  // ----------------------------------------
  // Run control
  // ----------------------------------------
  task automatic test_done;
    $display("Checks %0d, mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // Hang guard
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 4000) begin
      miscompares++;
      test_done;
    end
  end

  // Bus write; handshakes sampled at negedge, acted on at posedge
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic ta, tw, tb;
    tb = 1'b0;
    @(posedge aclk);
    awaddr <= a; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
    while (!tb) begin
      @(negedge aclk);
      ta = awvalid & awready; tw = wvalid & wready; tb = bvalid; rsp = bresp;
      @(posedge aclk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
    end
    bready <= 1'b0;
  endtask

  // Bus read into rd and rsp
  task automatic rdreg(input logic [7:0] a);
    logic ta, tr;
    tr = 1'b0;
    @(posedge aclk);
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    while (!tr) begin
      @(negedge aclk);
      ta = arvalid & arready; tr = rvalid; rd = rdata; rsp = rresp;
      @(posedge aclk);
      if (ta) arvalid <= 1'b0;
    end
    rready <= 1'b0;
  endtask

  // Rail change at a rising edge; settle wait ends at a falling edge
  task automatic setr(input int ch, input logic [8:0] v);
    @(posedge aclk);
    rail[ch] <= v;
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge aclk);
    @(negedge aclk);
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    aresetn = 1'b0; awvalid = 1'b0; wvalid = 1'b0; bready = 1'b0;
    arvalid = 1'b0; rready = 1'b0; awaddr = 8'h00; araddr = 8'h00;
    wdata = 32'h0; wstrb = 4'hF; dual_in = 5'h00; rail = {10{9'h080}};
    miscompares = 0; total_checks = 0;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    rdreg(8'h00); `CHK("cfg0 reset", 32'h0, rd)
    rdreg(8'h5C); `CHK("unmapped rresp", 2'h2, rsp)
    wr(8'h5C, 32'h1); `CHK("unmapped bresp", 2'h2, rsp)
    // Window, range 3, hysteresis 31, thresholds 0x40/0xC0
    wr(8'h00, 32'h039F_C040); rdreg(8'h00); `CHK("cfg0", 32'h039F_C040, rd)
    `CHK("range0", 2'h3, rng[0])
    `CHK("uv code0", 8'h40, uv_code[0])
    wr(8'h04, 32'h5);
    setr(0, 9'h030); repeat (2) @(posedge aclk); setr(0, 9'h080); wt(15);
    `CHK("short pulse", 1'b0, uvf[0])
    setr(0, 9'h030); wt(6); `CHK("uv early", 1'b0, uvf[0])
    wt(6); `CHK("uv late", 1'b1, uvf[0])
    `CHK("uv hyst code", 8'h5F, uv_code[0])
    rdreg(8'h50); `CHK("uv status", 32'h1, rd)
    setr(0, 9'h050); wt(15); `CHK("uv held", 1'b1, uvf[0])
    setr(0, 9'h060); wt(15); `CHK("uv clear", 1'b0, uvf[0])
    setr(0, 9'h0D0); wt(15); `CHK("ov set", 1'b1, ovf[0])
    `CHK("ov hyst code", 8'hA1, ov_code[0])
    rdreg(8'h54); `CHK("ov status", 32'h1, rd)
    setr(0, 9'h0B0); wt(15); `CHK("ov held", 1'b1, ovf[0])
    setr(0, 9'h090); wt(15); `CHK("ov clear", 1'b0, ovf[0])
    // Each mode code on channel 1
    for (int m = 0; m < 4; m++) begin
      wr(8'h08, {8'h00, 2'(m), 6'h0, 8'hC0, 8'h40});
      setr(1, 9'h030); wt(15); `CHK("mode uv", m[1:0] != 1 && m < 3, uvf[1])
      setr(1, 9'h0D0); wt(15); `CHK("mode ov", m == 1 || m == 2, ovf[1])
      setr(1, 9'h080);
    end
    wr(8'h0C, 32'h3FFF); rdreg(8'h0C); `CHK("clamp", {18'h0, FMAX}, rd)
    wr(8'h10, 32'h003F_0000); rdreg(8'h10); `CHK("hyst", 32'h001F_0000, rd)
    // Byte-lane strobe: only the overvoltage code byte lands
    @(posedge aclk);
    wstrb <= 4'h2;
    wr(8'h10, 32'hFFFF_ABFF);
    wstrb <= 4'hF;
    rdreg(8'h10);
    `CHK("strobe", 32'h001F_AB00, rd)
    // Dual channel 5 as logic input with warning on channel 0
    `CHK("no warn", 5'h00, warn)
    wr(8'h28, 32'h0400_0040); wt(2); `CHK("route", 5'h01, route)
    `CHK("range5", 2'h3, rng[5])
    setr(0, 9'h038); wt(20); `CHK("warn", 5'h01, warn)
    `CHK("warn any", 1'b1, warn_any)
    `CHK("dual no fault", 1'b0, uvf[5])
    @(posedge aclk); dual_in <= 5'h01; wt(15);
    `CHK("logic lvl", 5'h01, lvl)
    rdreg(8'h58); `CHK("warn status", 32'h0000_0101, rd)
    test_done;
  end
endmodule
